// ### rtl/pcx_crossbar.sv
`timescale 1ns/1ns
// Notes on behaviour
// - drivers default low strength, selectable high
// - fixed priority, uart first
// - lowest free pin per enabled resource
// - uart tx on P0.4, rx on P0.5
// - skip mask pins treated as taken
// - smbus and uart placed in pairs
// - leftover pins stay general purpose
// - slave select only in four-wire
// - only P0.0 to P2.7 allocatable
// - pin edges raise external events
// - no events on analog pins
// - crossbar off: all pins input
// - smbus pins always open drain
// - analog pins read as zero
module pcx_crossbar #(
	parameter int N  = pcx_pkg::NUM_PINS,
	parameter int NF = pcx_pkg::NUM_FUNCS
) (
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	input  wire logic [7:0]    crossbar_select_low_i,
	input  wire logic [7:0]    crossbar_select_high_i,
	input  wire logic [1:0]    slave_select_mode_field_i,
	input  wire logic [N-1:0]  pin_skip_mask_i,
	input  wire logic [N-1:0]  input_mode_select_i,
	input  wire logic [N-1:0]  output_mode_select_i,
	input  wire logic [N-1:0]  drive_strength_select_i,
	input  wire logic [N-1:0]  drive_strength_we_i,
	input  wire logic [N-1:0]  gpio_out_i,
	input  wire logic [NF-1:0] func_out_i,
	input  wire logic [NF-1:0] func_oe_i,
	input  wire logic [N-1:0]  pad_i,
	output logic      [N-1:0]  pad_o,
	output logic      [N-1:0]  pad_oe_o,
	output logic      [N-1:0]  pad_high_drive_o,
	output logic      [N-1:0]  weak_pullup_o,
	output logic      [N-1:0]  port_latch_o,
	output logic      [NF-1:0] func_in_o,
	output logic      [NF-1:0] func_placed_o,
	output logic      [N-1:0]  pin_assigned_o,
	output logic      [N-1:0]  event_o
);
	// ************************************************************
	// allocation
	// ************************************************************
	logic [NF-1:0]          req;
	logic [N-1:0]           taken;
	logic [NF-1:0]          placed_d, placed_q;
	logic [N-1:0]           assigned_d, assigned_q;
	logic [N-1:0]           is_smb_d, is_smb_q;
	logic [4:0]             owner_d [N];
	logic [4:0]             owner_q [N];
	logic                   xbar_en;
	logic [N-1:0]           pin_sync;

	assign xbar_en = crossbar_select_high_i[pcx_pkg::SEL_CROSSBAR_ENABLE_BIT];

	// lowest free pin in a mask; returns N when none is free
	function automatic logic [5:0] first_free(input logic [N-1:0] busy);
		logic [5:0] r;
		r = 6'(N);
		for (int i = N - 1; i >= 0; i--) begin
			if (!busy[i]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction

	always_comb begin
		logic four_wire;
		logic [5:0] p;
		logic [5:0] p2;
		four_wire = (slave_select_mode_field_i == pcx_pkg::SPI_4WIRE_LO) ||
			(slave_select_mode_field_i == pcx_pkg::SPI_4WIRE_HI);
		p = '0;
		p2 = '0;
		req = '0;
		req[pcx_pkg::PCX_F_UART_TX] = crossbar_select_low_i[pcx_pkg::SEL_UART_BIT];
		req[pcx_pkg::PCX_F_UART_RX] = crossbar_select_low_i[pcx_pkg::SEL_UART_BIT];
		req[pcx_pkg::PCX_F_SPI_SCK]  = crossbar_select_low_i[pcx_pkg::SEL_SPI_BIT];
		req[pcx_pkg::PCX_F_SPI_MISO] = crossbar_select_low_i[pcx_pkg::SEL_SPI_BIT];
		req[pcx_pkg::PCX_F_SPI_MOSI] = crossbar_select_low_i[pcx_pkg::SEL_SPI_BIT];
		req[pcx_pkg::PCX_F_SPI_NSS]  = crossbar_select_low_i[pcx_pkg::SEL_SPI_BIT] && four_wire;
		req[pcx_pkg::PCX_F_SMB_SDA] = crossbar_select_low_i[pcx_pkg::SEL_SMB_BIT];
		req[pcx_pkg::PCX_F_SMB_SCL] = crossbar_select_low_i[pcx_pkg::SEL_SMB_BIT];
		req[pcx_pkg::PCX_F_CMP]   = crossbar_select_low_i[pcx_pkg::SEL_CMP_BIT];
		req[pcx_pkg::PCX_F_CMPA]  = crossbar_select_low_i[pcx_pkg::SEL_CMPA_BIT];
		req[pcx_pkg::PCX_F_SYSCK] = crossbar_select_low_i[pcx_pkg::SEL_SYSCK_BIT];
		for (int c = 0; c < 3; c++) begin
			req[pcx_pkg::PCX_F_CEX0 + c] =
				(crossbar_select_high_i[pcx_pkg::SEL_PCA_LSB +: 2] > 2'(c));
		end
		req[pcx_pkg::PCX_F_ECI] = crossbar_select_high_i[pcx_pkg::SEL_ECI_BIT];
		req[pcx_pkg::PCX_F_T0]  = crossbar_select_high_i[pcx_pkg::SEL_T0_BIT];
		req[pcx_pkg::PCX_F_T1]  = crossbar_select_high_i[pcx_pkg::SEL_T1_BIT];

		taken = pin_skip_mask_i;
		placed_d = '0;
		assigned_d = '0;
		is_smb_d = '0;
		for (int i = 0; i < N; i++) begin
			owner_d[i] = '0;
		end
		if (req[pcx_pkg::PCX_F_UART_TX]) begin
			taken[pcx_pkg::UART_TX_PIN] = 1'b1;
			taken[pcx_pkg::UART_RX_PIN] = 1'b1;
			assigned_d[pcx_pkg::UART_TX_PIN] = 1'b1;
			assigned_d[pcx_pkg::UART_RX_PIN] = 1'b1;
			owner_d[pcx_pkg::UART_TX_PIN] = 5'(pcx_pkg::PCX_F_UART_TX);
			owner_d[pcx_pkg::UART_RX_PIN] = 5'(pcx_pkg::PCX_F_UART_RX);
			placed_d[pcx_pkg::PCX_F_UART_TX] = 1'b1;
			placed_d[pcx_pkg::PCX_F_UART_RX] = 1'b1;
		end
		for (int f = pcx_pkg::PCX_F_SPI_SCK; f < NF; f++) begin
			if (f == pcx_pkg::PCX_F_SMB_SDA) begin
				// smbus needs both lines or neither
				p = first_free(taken);
				p2 = (p < 6'(N)) ? first_free(taken | (N'(1) << p)) : 6'(N);
				if (req[f] && p2 < 6'(N)) begin
					taken[p[4:0]] = 1'b1;
					taken[p2[4:0]] = 1'b1;
					assigned_d[p[4:0]] = 1'b1;
					assigned_d[p2[4:0]] = 1'b1;
					is_smb_d[p[4:0]] = 1'b1;
					is_smb_d[p2[4:0]] = 1'b1;
					owner_d[p[4:0]] = 5'(pcx_pkg::PCX_F_SMB_SDA);
					owner_d[p2[4:0]] = 5'(pcx_pkg::PCX_F_SMB_SCL);
					placed_d[pcx_pkg::PCX_F_SMB_SDA] = 1'b1;
					placed_d[pcx_pkg::PCX_F_SMB_SCL] = 1'b1;
				end
			end else if (f != pcx_pkg::PCX_F_SMB_SCL) begin
				p = first_free(taken);
				if (req[f] && p < 6'(N)) begin
					taken[p[4:0]] = 1'b1;
					assigned_d[p[4:0]] = 1'b1;
					owner_d[p[4:0]] = 5'(f);
					placed_d[f] = 1'b1;
				end
			end
		end
		if (!xbar_en) begin
			assigned_d = '0;
			placed_d = '0;
			is_smb_d = '0;
		end
	end

	// ************************************************************
	// drive strength latch and registered allocation
	// ************************************************************
	logic [N-1:0] drive_d, drive_q;
	always_comb begin
		drive_d = (drive_q & ~drive_strength_we_i) | (drive_strength_select_i & drive_strength_we_i);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			drive_q    <= pcx_pkg::DRIVE_RST;
			placed_q   <= '0;
			assigned_q <= '0;
			is_smb_q   <= '0;
			for (int i = 0; i < N; i++) begin
				owner_q[i] <= '0;
			end
		end else begin
			drive_q    <= drive_d;
			placed_q   <= placed_d;
			assigned_q <= assigned_d;
			is_smb_q   <= is_smb_d;
			for (int i = 0; i < N; i++) begin
				owner_q[i] <= owner_d[i];
			end
		end
	end

	// ************************************************************
	// pad drive and input routing
	// ************************************************************
	logic [N-1:0] pad_d, pad_q, oe_d, oe_q, latch_d, latch_q, wpu_d, wpu_q;
	logic [NF-1:0] fin_d, fin_q;

	always_comb begin
		logic v;
		logic e;
		v = 1'b0;
		e = 1'b0;
		fin_d = '0;
		for (int i = 0; i < N; i++) begin
			if (assigned_q[i]) begin
				v = func_out_i[owner_q[i]];
				e = func_oe_i[owner_q[i]];
				fin_d[owner_q[i]] = pin_sync[i];
			end else begin
				v = gpio_out_i[i];
				e = 1'b1;
			end
			if (is_smb_q[i] || !output_mode_select_i[i]) begin
				e = e && !v;
			end
			oe_d[i] = xbar_en && input_mode_select_i[i] && e;
			pad_d[i] = v;
			latch_d[i] = input_mode_select_i[i] & pin_sync[i];
			// pullup only on digital pins not actively driving
			wpu_d[i] = input_mode_select_i[i] && !crossbar_select_high_i[pcx_pkg::SEL_WEAKPU_BIT] && !oe_d[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pad_q   <= '0;
			oe_q    <= '0;
			latch_q <= '0;
			wpu_q   <= '1;
			fin_q   <= '0;
		end else begin
			pad_q   <= pad_d;
			oe_q    <= oe_d;
			latch_q <= latch_d;
			wpu_q   <= wpu_d;
			fin_q   <= fin_d;
		end
	end

	// edge events on every digital pin
	pcx_event_detect #(
		.N(N)
	) u_events (
		.clk_i          (clk_i),
		.srst_i         (srst_i),
		.pad_i          (pad_i),
		.digital_mode_i (input_mode_select_i),
		.pin_sync_o     (pin_sync),
		.event_o        (event_o)
	);

	assign pad_o            = pad_q;
	assign pad_oe_o         = oe_q;
	assign pad_high_drive_o = drive_q;
	assign weak_pullup_o    = wpu_q;
	assign port_latch_o     = latch_q;
	assign func_in_o        = fin_q;
	assign func_placed_o    = placed_q;
	assign pin_assigned_o   = assigned_q;
endmodule

// ### shared/pcx_pkg.sv
package pcx_pkg;
	// ************************************************************
	// pin space and fixed uart placement
	// ************************************************************
	localparam int          NUM_PINS      = 24;
	localparam int          PIN_IDX_W     = 5;
	localparam int          UART_TX_PIN   = 4;
	localparam int          UART_RX_PIN   = 5;
	localparam int          NUM_FUNCS     = 17;

	// ************************************************************
	// crossbar_select_low fields
	// ************************************************************
	localparam int          SEL_UART_BIT  = 0;
	localparam int          SEL_SPI_BIT   = 1;
	localparam int          SEL_SMB_BIT   = 2;
	localparam int          SEL_SYSCK_BIT = 3;
	localparam int          SEL_CMP_BIT   = 4;
	localparam int          SEL_CMPA_BIT  = 5;
	localparam logic [7:0]  SEL_LOW_RST   = 8'h00;

	// ************************************************************
	// crossbar_select_high fields
	// ************************************************************
	localparam int          SEL_PCA_LSB   = 0;
	localparam int          SEL_ECI_BIT   = 3;
	localparam int          SEL_T0_BIT    = 4;
	localparam int          SEL_T1_BIT    = 5;
	localparam int          SEL_CROSSBAR_ENABLE_BIT = 6;
	localparam int          SEL_WEAKPU_BIT = 7;
	localparam logic [7:0]  SEL_HIGH_RST  = 8'h00;

	// slave_select_mode_field values that select four-wire operation
	localparam logic [1:0]  SPI_4WIRE_LO  = 2'h2;
	localparam logic [1:0]  SPI_4WIRE_HI  = 2'h3;

	localparam logic [23:0] DRIVE_RST     = 24'h000000;

	// ************************************************************
	// functions in priority order; slot numbers index func_out_i, func_oe_i and func_in_o
	// ************************************************************
	typedef enum logic [4:0] {
		PCX_F_UART_TX, PCX_F_UART_RX,
		PCX_F_SPI_SCK, PCX_F_SPI_MISO, PCX_F_SPI_MOSI, PCX_F_SPI_NSS,
		PCX_F_SMB_SDA, PCX_F_SMB_SCL,
		PCX_F_CMP, PCX_F_CMPA, PCX_F_SYSCK,
		PCX_F_CEX0, PCX_F_CEX1, PCX_F_CEX2,
		PCX_F_ECI, PCX_F_T0, PCX_F_T1
	} pcx_func_t;
endpackage

// ### rtl/pcx_event_detect.sv
`timescale 1ns/1ns
module pcx_event_detect #(
	parameter int N = 24
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [N-1:0] pad_i,
	input  wire logic [N-1:0] digital_mode_i,
	output logic      [N-1:0] pin_sync_o,
	output logic      [N-1:0] event_o
);
	// ************************************************************
	// pad synchroniser and edge detect
	// ************************************************************
	logic [N-1:0] meta_q, sync_q, prev_q;
	logic [N-1:0] meta_d, sync_d, prev_d, ev_d, ev_q;

	always_comb begin
		meta_d = pad_i;
		sync_d = meta_q;
		prev_d = sync_q;
		ev_d   = (sync_q ^ prev_q) & digital_mode_i;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			// pads idle high under the reset pull-ups; matching that avoids a false edge
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
			ev_q   <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			ev_q   <= ev_d;
		end
	end

	assign pin_sync_o = sync_q;
	assign event_o    = ev_q;
endmodule

// ### testbench/pcx_sva.sv
`timescale 1ns/1ns
module pcx_sva #(
	parameter int N  = 24,
	parameter int NF = 17
) (
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	input  wire logic [7:0]    crossbar_select_low_i,
	input  wire logic [7:0]    crossbar_select_high_i,
	input  wire logic [1:0]    slave_select_mode_field_i,
	input  wire logic [N-1:0]  pin_skip_mask_i,
	input  wire logic [N-1:0]  input_mode_select_i,
	input  wire logic [N-1:0]  drive_strength_select_i,
	input  wire logic [N-1:0]  drive_strength_we_i,
	input  wire logic [N-1:0]  pad_oe_o,
	input  wire logic [N-1:0]  pad_high_drive_o,
	input  wire logic [N-1:0]  port_latch_o,
	input  wire logic [NF-1:0] func_placed_o,
	input  wire logic [N-1:0]  pin_assigned_o,
	input  wire logic [N-1:0]  event_o
);
	// ************************************************************
	// crossbar placement and pad checks
	// ************************************************************
	logic [7:0] lo;
	logic [7:0] hi;
	logic [N-1:0] im;
	assign lo = crossbar_select_low_i;
	assign hi = crossbar_select_high_i;
	assign im = input_mode_select_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// pad enables lag the select by one cycle; the check waits for off to hold for two
	sequence s_off2;
		!hi[6] ##1 !hi[6];
	endsequence
	property p_off;
		s_off2 |=> pin_assigned_o == '0 && pad_oe_o == '0;
	endproperty
	a_off: assert property (p_off) else $error("pin claimed while crossbar off");
	property p_uart;
		lo[0] && hi[6] |=> pin_assigned_o[5:4] == 2'h3 && func_placed_o[1:0] == 2'h3;
	endproperty
	a_uart: assert property (p_uart) else $error("uart not on its fixed pins");
	property p_pair;
		func_placed_o[7] == func_placed_o[6] && func_placed_o[1] == func_placed_o[0];
	endproperty
	a_pair: assert property (p_pair) else $error("paired lines split");
	property p_nss;
		func_placed_o[5] |-> $past(slave_select_mode_field_i[1] && lo[1]);
	endproperty
	a_nss: assert property (p_nss) else $error("slave select placed in three-wire");
	property p_skip;
		(pin_assigned_o & $past(pin_skip_mask_i) & 24'hFFFFCF) == '0;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped pin was claimed");
	property p_contig;
		$past(pin_skip_mask_i) == '0 && !$past(lo[0]) |-> ((pin_assigned_o + 1'b1) & pin_assigned_o) == '0;
	endproperty
	a_contig: assert property (p_contig) else $error("claimed pins not packed from the bottom");
	property p_drv;
		1'b1 |=> ((pad_high_drive_o ^ $past(drive_strength_select_i)) & $past(drive_strength_we_i)) == '0;
	endproperty
	a_drv: assert property (p_drv) else $error("drive strength write lost");
	property p_drv_rst;
		disable iff (1'b0) srst_i |=> pad_high_drive_o == '0;
	endproperty
	a_drv_rst: assert property (p_drv_rst) else $error("drive not low after reset");
	property p_latch;
		(port_latch_o & ~($past(im) | $past(im, 2))) == '0;
	endproperty
	a_latch: assert property (p_latch) else $error("analog pin reads nonzero");
	property p_evt;
		(event_o & ~(im | $past(im) | $past(im, 2) | $past(im, 3) | $past(im, 4))) == '0;
	endproperty
	a_evt: assert property (p_evt) else $error("event on analog pin");
endmodule

// ### testbench/pcx_pad_model.sv
`timescale 1ns/1ns
module pcx_pad_model (
	input  wire logic        clk_i,
	input  wire logic [23:0] pad_out_i,
	input  wire logic [23:0] pad_oe_i,
	input  wire logic [23:0] pullup_i,
	input  wire logic [23:0] ext_en_i,
	input  wire logic [23:0] ext_val_i,
	output logic      [23:0] pad_o
);
	// ************************************************************
	// pad resolution
	// ************************************************************
	// an undriven pad without pull-up wanders, so stale values never pass
	logic [23:0] float_q = 24'h5A5A5A;
	always @(posedge clk_i) float_q <= ~float_q;
	assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
		| (~pad_oe_i & ~ext_en_i & (pullup_i | float_q));
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  lo = 8'h00, hi = 8'h00;
	logic [1:0]  md = 2'h0;
	logic [23:0] sk = 24'h0, im = 24'hFFFFFF, om = 24'h0, ds = 24'h0, dw = 24'h0;
	logic [23:0] go = 24'h0, xe = 24'h0, xv = 24'h0, exp_drv = 24'h0;
	logic [16:0] fo = 17'h0, fe = 17'h0, placed, fin;
	logic [23:0] pad_i, pad_o, pad_oe_o, hd, wp, evt, asg, lat;
	logic [31:0] seed = 32'h0000B5B0;
	int          mismatches = 0, checks_done = 0;
	pcx_crossbar pcx_crossbar_i (.clk_i(clk_i), .srst_i(srst_i), .crossbar_select_low_i(lo),
		.crossbar_select_high_i(hi), .slave_select_mode_field_i(md), .pin_skip_mask_i(sk),
		.input_mode_select_i(im), .output_mode_select_i(om), .drive_strength_select_i(ds),
		.drive_strength_we_i(dw), .gpio_out_i(go), .func_out_i(fo), .func_oe_i(fe), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe_o(pad_oe_o), .pad_high_drive_o(hd), .weak_pullup_o(wp), .port_latch_o(lat),
		.func_in_o(fin), .func_placed_o(placed), .pin_assigned_o(asg), .event_o(evt));
	pcx_pad_model pcx_pad_model_i (.clk_i(clk_i), .pad_out_i(pad_o), .pad_oe_i(pad_oe_o), .pullup_i(wp),
		.ext_en_i(xe), .ext_val_i(xv), .pad_o(pad_i));
	// ************************************************************
	// reference and checking
	// ************************************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [40:0] xb_ref(logic [7:0] l, logic [7:0] h, logic [1:0] m, logic [23:0] s);
		logic [23:0] used;
		logic [23:0] a;
		logic [16:0] f;
		logic [16:0] want;
		int          p;
		used = s;
		a = '0;
		f = '0;
		want = {h[5], h[4], h[3], h[1:0] == 2'h3, h[1], h[1:0] != 2'h0, l[3], l[5], l[4], {2{l[2]}},
			l[1] & m[1], {3{l[1]}}, 2'h0};
		if (!h[6]) return '0;
		if (l[0]) begin
			used[5:4] = 2'h3;
			a[5:4] = 2'h3;
			f[1:0] = 2'h3;
		end
		// smbus needs two free pins or takes none
		for (int k = 2; k < 17; k++) begin
			if (k == 6 && $countones(~used) < 2) k++;
			else if (want[k] && used != 24'hFFFFFF) begin
				p = 0;
				while (used[p]) p++;
				used[p] = 1'b1;
				a[p] = 1'b1;
				f[k] = 1'b1;
			end
		end
		return {f, a};
	endfunction
	task automatic cmp_alloc(input logic [40:0] got, input logic [40:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: placement %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bits(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pads(input logic [23:0] oe, input logic [23:0] po, input logic [23:0] pu,
		input logic [23:0] pl, input logic [16:0] fi);
		repeat (5) @(posedge clk_i);
		#1 cmp_bits(pad_oe_o, oe);
		cmp_bits(pad_o, po);
		cmp_bits(wp, pu);
		cmp_bits(lat, pl);
		cmp_bits({7'h0, fin}, {7'h0, fi});
	endtask
	task automatic apply(input logic [7:0] l, input logic [7:0] h, input logic [1:0] m, input logic [23:0] s);
		@(posedge clk_i);
		{lo, hi, md, sk} <= {l, h, m, s};
		repeat (3) @(posedge clk_i);
		#1 cmp_alloc({placed, asg}, xb_ref(l, h, m, s));
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		report_and_stop();
	end
	initial begin
		logic [31:0] r;
		int          k;
		logic [23:0] an;
		logic [23:0] sv;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		#1 cmp_bits(hd, pcx_pkg::DRIVE_RST);
		apply(8'h07, 8'h43, 2'h2, 24'h000000);
		apply(8'h07, 8'h43, 2'h0, 24'h00010C);
		// only pins 0 to 3 free: spi fills three, smbus has one left
		apply(8'h3F, 8'h7F, 2'h1, 24'hFFFFC0);
		apply(8'h3F, 8'h3F, 2'h3, 24'h000000);
		cmp_bits(pad_oe_o, 24'h000000);
		apply(8'h3E, 8'h7F, 2'h3, 24'h000000);
		for (int i = 0; i < 150; i++) begin
			r = xs();
			// software skips analog pins and keeps the fixed uart pins free
			an = 24'(xs()) & r[23:0] & 24'hFFFFCF;
			sv = (24'(xs() & xs()) | an) & 24'hFFFFCF;
			@(posedge clk_i);
			go <= 24'(xs());
			fo <= 17'(xs());
			fe <= 17'(xs());
			om <= 24'(xs());
			ds <= r[31:8];
			dw <= 24'(xs());
			im <= ~an;
			apply(r[7:0], {r[15], r[16] | r[17], r[13:8]}, r[25:24], sv);
			exp_drv = (exp_drv & ~dw) | (ds & dw);
			cmp_bits(hd, exp_drv);
		end
		// smbus lines released high, then pulled low, with push-pull selected
		@(posedge clk_i);
		{im, om, go, fo, fe, xe} <= {24'h7FFFFF, 24'hFFFFFF, 24'hA5A5A5, 17'h1FFFF, 17'h1FFFF, 24'h000000};
		apply(8'h04, 8'h40, 2'h0, 24'h000000);
		chk_pads(24'h7FFFFC, 24'hA5A5A7, 24'h000003, 24'h25A5A7, 17'h000C0);
		@(posedge clk_i);
		fo <= 17'h00000;
		chk_pads(24'h7FFFFF, 24'hA5A5A4, 24'h000000, 24'h25A5A4, 17'h00000);
		@(posedge clk_i);
		{im, om, go, sk, xe, hi} <= {24'hFFFFFF, 24'h0, 24'hFFFFFF, 24'hFFFFFF, 24'h000100, 8'h40};
		repeat (2) begin
			repeat (8) @(posedge clk_i);
			xv[8] <= ~xv[8];
			k = 0;
			while (evt[8] !== 1'b1 && k < 10) begin
				@(posedge clk_i);
				#1 k++;
			end
			cmp_bits({23'h0, evt[8]}, 24'h000001);
		end
		report_and_stop();
	end
endmodule
bind pcx_crossbar pcx_sva #(.N(N), .NF(NF)) pcx_sva_i (.*);
